// ==== gmt_timer.v ====
// gated modulo timer: 8-bit counter, clock select, gate control, irq, ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - an 8-bit counter advances on the selected basic clock and in modulo mode is compared with a loaded value.
// - the two-bit clock select picks 100 kHz, 10 kHz, 2 kHz or 1 kHz for codes 00, 01, 10, 11.
// - in gate mode the counter counts basic clocks while the external gate is open, measuring pulse width.
// - bit 0 of the mode register chooses modulo operation (0) or gate counter operation (1).
// - the basic clock reaches the counter only while the run bit is 1, qualified by mode and gate.
// - mode bits 1 and 2 pick a rising (1) or falling (0) gate edge for opening and for closing.
// - detecting the programmed gate close edge raises an interrupt request.
// - writing 1 to the clear bit resets the counter and writing 0 leaves it alone.
// - the clear bit always reads back as 0.
// - bit 3 of the mode register flags that the 8-bit counter overflowed in gate mode.
// - in modulo mode the count resets when it equals the modulo value and requests an interrupt.
// - in gate mode a modulo match raises no interrupt and the count wraps to 00H on overflow.
// - a counter overflow can request an interrupt besides setting the overflow flag.
`include "gmt_timer_defs.vh"

module gmt_timer #(
    parameter DIV_100K = `GMT_T100K_NS / `GMT_HCLK_NS,
    parameter DIV_10K  = `GMT_T10K_NS / `GMT_HCLK_NS,
    parameter DIV_2K   = `GMT_T2K_NS / `GMT_HCLK_NS,
    parameter DIV_1K   = `GMT_T1K_NS / `GMT_HCLK_NS
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        gate_input_pin,
    output reg         gate_open_out,
    output reg         irq
);

    // ****************************************
    // gate state machine codes
    // ****************************************
    localparam [1:0] GATE_CLOSED = 2'b01;
    localparam [1:0] GATE_OPEN   = 2'b10;

    // ****************************************
    // declarations
    // ****************************************
    reg                    wr_pend_reg;
    reg  [7:0]             wr_addr_reg;
    reg  [1:0]             clk_sel_reg;
    reg                    run_reg;
    reg                    gate_mode_reg;
    reg                    open_rise_reg;
    reg                    close_rise_reg;
    reg                    ovf_flag_reg;
    reg  [7:0]             count_reg;
    reg  [7:0]             modulo_reg;
    reg  [2:0]             irq_stat_reg;
    reg  [2:0]             irq_mask_reg;
    reg  [`GMT_PRE_W-1:0]  pre_cnt_reg;
    reg                    gate_prev_reg;
    reg  [1:0]             gate_state_reg;
    reg  [1:0]             gate_state_next;
    reg  [7:0]             count_next;
    reg  [2:0]             irq_stat_next;
    reg  [`GMT_PRE_W-1:0]  div_sel;
    reg  [31:0]            rdata_next;
    wire                   addr_phase;
    wire                   wr_data;
    wire                   wr_clkrun;
    wire                   wr_mode;
    wire                   wr_modulo;
    wire                   wr_stat;
    wire                   wr_mask;
    wire                   clear_cmd;
    wire                   basic_tick;
    wire                   rise_edge;
    wire                   fall_edge;
    wire                   open_edge;
    wire                   close_edge;
    wire                   gate_passes;
    wire                   count_tick;
    wire                   match_hit;
    wire                   ovf_hit;
    wire [2:0]             irq_events;

    // ****************************************
    // ahb-lite address phase capture
    // ****************************************
    // a transfer is taken only when the bus is ready and htrans is non-sequential or sequential
    assign addr_phase = hsel & htrans[`GMT_HTRANS_NSEQ] & hready;

    // writes land one cycle later with hwdata, so the address is held for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // data phase strobes per register
    assign wr_data   = wr_pend_reg;
    assign wr_clkrun = wr_data & (wr_addr_reg == `GMT_ADDR_CLKRUN);
    assign wr_mode   = wr_data & (wr_addr_reg == `GMT_ADDR_MODE);
    assign wr_modulo = wr_data & (wr_addr_reg == `GMT_ADDR_MODULO);
    assign wr_stat   = wr_data & (wr_addr_reg == `GMT_ADDR_IRQ_STAT);
    assign wr_mask   = wr_data & (wr_addr_reg == `GMT_ADDR_IRQ_MASK);

    // the clear bit is a pure command, never stored
    assign clear_cmd = wr_clkrun & hwdata[`GMT_CLK_CLEAR];

    // ****************************************
    // bus answer: zero wait states, always okay
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data is chosen in the address phase so hrdata comes straight from a flop
    always @* begin
        rdata_next = `GMT_ZERO32;
        case (haddr[7:0])
            `GMT_ADDR_CLKRUN: begin
                rdata_next[`GMT_CLK_SEL_HI:`GMT_CLK_SEL_LO] = clk_sel_reg;
                rdata_next[`GMT_CLK_CLEAR] = 1'b0;
                rdata_next[`GMT_CLK_RUN]   = run_reg;
            end
            `GMT_ADDR_MODE: begin
                rdata_next[`GMT_MODE_GATE]       = gate_mode_reg;
                rdata_next[`GMT_MODE_OPEN_EDGE]  = open_rise_reg;
                rdata_next[`GMT_MODE_CLOSE_EDGE] = close_rise_reg;
                rdata_next[`GMT_MODE_OVF]        = ovf_flag_reg;
            end
            `GMT_ADDR_COUNT: begin
                rdata_next[7:0] = count_reg;
            end
            `GMT_ADDR_MODULO: begin
                rdata_next[7:0] = modulo_reg;
            end
            `GMT_ADDR_IRQ_STAT: begin
                rdata_next[2:0] = irq_stat_reg;
            end
            `GMT_ADDR_IRQ_MASK: begin
                rdata_next[2:0] = irq_mask_reg;
            end
            default: begin
                rdata_next = `GMT_ZERO32;
            end
        endcase
    end

    // hold the last read data between transfers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `GMT_ZERO32;
        end else if (addr_phase & ~hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // select and run clear to zero on reset; there is no retaining reset here
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_reg <= `GMT_SEL_RST;
            run_reg     <= 1'b0;
        end else if (wr_clkrun) begin
            clk_sel_reg <= hwdata[`GMT_CLK_SEL_HI:`GMT_CLK_SEL_LO];
            run_reg     <= hwdata[`GMT_CLK_RUN];
        end
    end

    // mode and edge selection
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_mode_reg  <= 1'b0;
            open_rise_reg  <= 1'b0;
            close_rise_reg <= 1'b0;
        end else if (wr_mode) begin
            gate_mode_reg  <= hwdata[`GMT_MODE_GATE];
            open_rise_reg  <= hwdata[`GMT_MODE_OPEN_EDGE];
            close_rise_reg <= hwdata[`GMT_MODE_CLOSE_EDGE];
        end
    end

    // modulo value, loaded by software before counting starts
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modulo_reg <= `GMT_MODULO_RST;
        end else if (wr_modulo) begin
            modulo_reg <= hwdata[7:0];
        end
    end

    // overflow flag: a fresh overflow beats a software write of 0 in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_hit) begin
            ovf_flag_reg <= 1'b1;
        end else if (wr_mode & ~hwdata[`GMT_MODE_OVF]) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // ****************************************
    // basic clock prescaler
    // ****************************************
    // pick the division for the selected basic clock
    always @* begin
        case (clk_sel_reg)
            `GMT_SEL_100K: div_sel = DIV_100K[`GMT_PRE_W-1:0];
            `GMT_SEL_10K:  div_sel = DIV_10K[`GMT_PRE_W-1:0];
            `GMT_SEL_2K:   div_sel = DIV_2K[`GMT_PRE_W-1:0];
            `GMT_SEL_1K:   div_sel = DIV_1K[`GMT_PRE_W-1:0];
            default:       div_sel = DIV_100K[`GMT_PRE_W-1:0];
        endcase
    end

    // >= rather than == so a switch to a shorter period never misses the wrap
    assign basic_tick = run_reg & (pre_cnt_reg >= (div_sel - 1'b1));

    // held at zero while stopped so the first period after start is a full one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_reg <= {`GMT_PRE_W{1'b0}};
        end else if (~run_reg | basic_tick) begin
            pre_cnt_reg <= {`GMT_PRE_W{1'b0}};
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
        end
    end

    // ****************************************
    // gate edge detection and gate state
    // ****************************************
    // the pin is taken as synchronous, one flop gives the previous level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_prev_reg <= 1'b0;
        end else begin
            gate_prev_reg <= gate_input_pin;
        end
    end

    assign rise_edge  = gate_input_pin & ~gate_prev_reg;
    assign fall_edge  = ~gate_input_pin & gate_prev_reg;
    assign open_edge  = open_rise_reg ? rise_edge : fall_edge;
    assign close_edge = close_rise_reg ? rise_edge : fall_edge;

    // opening needs a closed gate and closing an open one, so equal edges alternate
    always @* begin
        gate_state_next = gate_state_reg;
        case (gate_state_reg)
            GATE_CLOSED: begin
                if (gate_mode_reg & run_reg & open_edge) begin
                    gate_state_next = GATE_OPEN;
                end
            end
            GATE_OPEN: begin
                if (~gate_mode_reg | ~run_reg | close_edge) begin
                    gate_state_next = GATE_CLOSED;
                end
            end
            default: begin
                gate_state_next = GATE_CLOSED;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_state_reg <= GATE_CLOSED;
            gate_open_out  <= 1'b0;
        end else begin
            gate_state_reg <= gate_state_next;
            gate_open_out  <= (gate_state_next == GATE_OPEN);
        end
    end

    // ****************************************
    // count block
    // ****************************************
    // modulo mode counts freely; gate mode only while the gate is open
    assign gate_passes = ~gate_mode_reg | (gate_state_reg == GATE_OPEN);
    assign count_tick  = basic_tick & gate_passes;
    assign match_hit   = count_tick & ~gate_mode_reg & (count_reg == modulo_reg);
    assign ovf_hit     = count_tick & gate_mode_reg & (count_reg == `GMT_COUNT_MAX);

    // clear wins over a tick in the same cycle
    always @* begin
        count_next = count_reg;
        if (clear_cmd) begin
            count_next = `GMT_COUNT_RST;
        end else if (match_hit) begin
            count_next = `GMT_COUNT_RST;
        end else if (count_tick) begin
            count_next = count_reg + `GMT_COUNT_ONE;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `GMT_COUNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // gate mode never posts the match event
    assign irq_events[`GMT_IRQ_MATCH] = match_hit;
    assign irq_events[`GMT_IRQ_GATE]  = (gate_state_reg == GATE_OPEN) & gate_mode_reg
                                        & run_reg & close_edge;
    assign irq_events[`GMT_IRQ_OVF]   = ovf_hit;

    // write one to clear; an event in the clearing cycle stays set
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_stat) begin
            irq_stat_next = irq_stat_reg & ~hwdata[2:0];
        end
        irq_stat_next = irq_stat_next | irq_events;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= `GMT_IRQ_RST;
            irq_mask_reg <= `GMT_IRQ_RST;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_mask) begin
                irq_mask_reg <= hwdata[2:0];
            end
            // one cycle behind the status so the output stays a flop
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule

// ==== gmt_timer_defs.vh ====
// register map, field positions, reset values and timing constants of the gated modulo timer
`ifndef GMT_TIMER_DEFS_VH
`define GMT_TIMER_DEFS_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define GMT_IDX_MODULO   8'h1A
`define GMT_IDX_COUNT    8'h1B
`define GMT_IDX_MODE     8'h2A
`define GMT_IDX_CLKRUN   8'h2B
`define GMT_IDX_IRQ_STAT 8'h30
`define GMT_IDX_IRQ_MASK 8'h31
`define GMT_ADDR_STEP    8'h04
`define GMT_ADDR_MODULO   (`GMT_IDX_MODULO * `GMT_ADDR_STEP)
`define GMT_ADDR_COUNT    (`GMT_IDX_COUNT * `GMT_ADDR_STEP)
`define GMT_ADDR_MODE     (`GMT_IDX_MODE * `GMT_ADDR_STEP)
`define GMT_ADDR_CLKRUN   (`GMT_IDX_CLKRUN * `GMT_ADDR_STEP)
`define GMT_ADDR_IRQ_STAT (`GMT_IDX_IRQ_STAT * `GMT_ADDR_STEP)
`define GMT_ADDR_IRQ_MASK (`GMT_IDX_IRQ_MASK * `GMT_ADDR_STEP)

// ****************************************
// field positions
// ****************************************
`define GMT_CLK_SEL_LO   0
`define GMT_CLK_SEL_HI   1
`define GMT_CLK_CLEAR    2
`define GMT_CLK_RUN      3
`define GMT_MODE_GATE    0
`define GMT_MODE_OPEN_EDGE  1
`define GMT_MODE_CLOSE_EDGE 2
`define GMT_MODE_OVF     3
`define GMT_IRQ_MATCH    0
`define GMT_IRQ_GATE     1
`define GMT_IRQ_OVF      2

// ****************************************
// reset values and codes
// ****************************************
`define GMT_CLKRUN_RST   4'h0
`define GMT_SEL_RST      2'h0
`define GMT_MODE_RST     4'h0
`define GMT_COUNT_RST    8'h00
`define GMT_COUNT_MAX    8'hFF
`define GMT_COUNT_ONE    8'h01
`define GMT_MODULO_RST   8'hFF
`define GMT_IRQ_RST      3'h0
`define GMT_SEL_100K     2'h0
`define GMT_SEL_10K      2'h1
`define GMT_SEL_2K       2'h2
`define GMT_SEL_1K       2'h3
`define GMT_HTRANS_NSEQ  1
`define GMT_ZERO32       32'h0000_0000

// ****************************************
// basic clock periods in ns, system clock period in ns
// ****************************************
`define GMT_HCLK_NS      40
`define GMT_T100K_NS     10000
`define GMT_T10K_NS      100000
`define GMT_T2K_NS       500000
`define GMT_T1K_NS       1000000
`define GMT_PRE_W        15

`endif

// ==== gmt_timer_properties.sv ====
// port-level assertions of the gated modulo timer and their bind
`timescale 1ns/1ps
`include "gmt_timer_defs.vh"
module gmt_timer_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        hresp,
    input wire        gate_input_pin,
    input wire        gate_open_out,
    input wire        irq
);
    // ****************************************
    // helper logic
    // ****************************************
    wire       rd_tk = hsel && htrans[1] && hready && !hwrite;
    wire       wr_tk = hsel && htrans[1] && hready && hwrite;
    wire       pin_edge;
    reg  [2:0] since_wr_reg;
    // cycles since a write was taken; saturates so an old write never looks fresh
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_wr_reg <= 3'h7;
        end else if (wr_tk) begin
            since_wr_reg <= 3'h0;
        end else if (since_wr_reg != 3'h7) begin
            since_wr_reg <= since_wr_reg + 3'h1;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pin_moved;
        $past(gate_input_pin) != $past(gate_input_pin, 2);
    endsequence
    property p_ready; hreadyout == 1'b1; endproperty
    property p_resp; hresp == 1'b0; endproperty
    property p_rd_hold; !$past(rd_tk) |-> $stable(hrdata); endproperty
    property p_rd_high; rd_tk |=> hrdata[31:8] == 24'h00_0000; endproperty
    property p_clr_zero;
        rd_tk && haddr[7:0] == `GMT_ADDR_CLKRUN |=> hrdata[`GMT_CLK_CLEAR] == 1'b0;
    endproperty
    property p_gate_open; $rose(gate_open_out) |-> s_pin_moved; endproperty
    property p_gate_shut;
        $fell(gate_open_out) |-> s_pin_moved or since_wr_reg <= 3'h4;
    endproperty
    property p_irq_drop; $fell(irq) |-> since_wr_reg <= 3'h4; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    a_resp: assert property (p_resp) else $error("error response seen");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_rd_high: assert property (p_rd_high) else $error("upper read bits set");
    a_clr_zero: assert property (p_clr_zero) else $error("clear bit read 1");
    a_gate_open: assert property (p_gate_open) else $error("gate opened");
    a_gate_shut: assert property (p_gate_shut) else $error("gate closed");
    a_irq_drop: assert property (p_irq_drop) else $error("irq dropped");
    c_irq: cover property ($rose(irq));
    c_gate: cover property ($fell(gate_open_out));
    c_clr: cover property (rd_tk && haddr[7:0] == `GMT_ADDR_CLKRUN);
endmodule
bind gmt_timer gmt_timer_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .gate_input_pin(gate_input_pin), .gate_open_out(gate_open_out), .irq(irq));

// ==== gmt_gate_src.sv ====
// external pulse source that drives the gate input of the timer
`timescale 1ns/1ps
module gmt_gate_src (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        start,
    input  wire [15:0] width,
    input  wire        invert,
    output wire        gate_input_pin
);
    reg [15:0] cnt_reg;
    reg        level_reg;
    // one pulse of exactly width cycles; invert makes it a low-going pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg   <= 16'h0000;
            level_reg <= 1'b0;
        end else if (start) begin
            cnt_reg   <= width;
            level_reg <= 1'b1;
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
            if (cnt_reg == 16'h0001) begin
                level_reg <= 1'b0;
            end
        end
    end
    assign gate_input_pin = level_reg ^ invert;
endmodule

// ==== gmt_timer_tb.sv ====
// self-checking bench of the gated modulo timer with a pulse source on its gate
`timescale 1ns/1ps
`include "gmt_timer_defs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module gmt_timer_tb;
    // ****************************************
    // signals, tables and instances
    // ****************************************
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0000_0000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [2:0]  hsize = 3'h2;
    reg  [31:0] hwdata = 32'h0000_0000;
    reg         start = 1'b0;
    reg  [15:0] width = 16'h0000;
    reg         invert = 1'b0;
    reg         rd_pend = 1'b0;
    reg  [31:0] v;
    reg  [31:0] exp_v;
    reg  [31:0] exp_q[$];
    wire        hready;
    wire [31:0] hrdata;
    wire        hresp;
    wire        gate_pin;
    wire        gate_open_out;
    wire        irq;
    int         n_fail = 0;
    int         n_compared = 0;
    int         dv[4] = '{4, 6, 8, 10};
    int         gp[2] = '{1040, 80};
    reg  [31:0] ra[7] = '{`GMT_ADDR_MODULO, `GMT_ADDR_MODE, `GMT_ADDR_CLKRUN,
                          `GMT_ADDR_IRQ_STAT, `GMT_ADDR_IRQ_MASK, `GMT_ADDR_COUNT, 8'h10};
    reg  [31:0] rv[7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    reg  [31:0] gm[2] = '{8'h03, 8'h05};
    reg  [31:0] gc[2] = '{8'h04, 8'h14};
    reg  [31:0] ge[2] = '{8'h0B, 8'h05};
    reg  [31:0] gs[2] = '{8'h06, 8'h02};
    gmt_timer #(.DIV_100K(4), .DIV_10K(6), .DIV_2K(8), .DIV_1K(10)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .gate_input_pin(gate_pin), .gate_open_out(gate_open_out), .irq(irq));
    gmt_gate_src u_src (.hclk(hclk), .hresetn(hresetn), .start(start), .width(width),
        .invert(invert), .gate_input_pin(gate_pin));
    always #20 hclk = ~hclk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic close_out;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // bounded wait for an edge with hready high; a hung slave ends the run
    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && i < 20) begin
            @(posedge hclk);
            i++;
        end
        if (hready !== 1'b1) begin
            n_fail++;
            close_out;
        end
    endtask
    // one single transfer; for a read d is the value expected back
    task automatic bus(input reg wr, input reg [31:0] a, input reg [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) begin
            hwdata <= d;
        end else begin
            rd_pend <= 1'b1;
            exp_q.push_back(d);
        end
        wait_rdy;
        rd_pend <= 1'b0;
    endtask
    // irq is a level that lags status, so give it a few cycles to settle
    task automatic look(input reg e);
        repeat (3) @(posedge hclk);
        #1;
        `CHK(irq, e)
    endtask
    // oldest noted read value is compared when its data phase ends
    always @(posedge hclk) begin
        if (rd_pend === 1'b1 && hready === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK(hrdata, exp_v)
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        v = $urandom(24);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, ra[i], rv[i]);
        end
        // stop halfway between ticks so a one-cycle latency choice cannot matter
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `GMT_ADDR_CLKRUN, 32'(12 + s));
            repeat (dv[s] * 5 + dv[s] / 2 - 3) @(posedge hclk);
            bus(1'b1, `GMT_ADDR_CLKRUN, 32'(s));
            bus(1'b0, `GMT_ADDR_COUNT, 32'h05);
            bus(1'b1, `GMT_ADDR_CLKRUN, 32'(4 + s));
            bus(1'b0, `GMT_ADDR_CLKRUN, 32'(s));
            bus(1'b0, `GMT_ADDR_COUNT, 32'h00);
        end
        bus(1'b1, `GMT_ADDR_COUNT, 32'h55);
        bus(1'b0, `GMT_ADDR_COUNT, 32'h00);
        // modulo 2 wraps 0,1,2,0: seven ticks leave a count of one
        bus(1'b1, `GMT_ADDR_MODULO, 32'h02);
        bus(1'b1, `GMT_ADDR_IRQ_MASK, 32'h01);
        bus(1'b1, `GMT_ADDR_CLKRUN, 32'h0C);
        repeat (27) @(posedge hclk);
        bus(1'b1, `GMT_ADDR_CLKRUN, 32'h00);
        bus(1'b0, `GMT_ADDR_COUNT, 32'h01);
        bus(1'b0, `GMT_ADDR_IRQ_STAT, 32'h01);
        look(1'b1);
        bus(1'b1, `GMT_ADDR_IRQ_MASK, 32'h00);
        look(1'b0);
        bus(1'b1, `GMT_ADDR_IRQ_MASK, 32'h01);
        look(1'b1);
        bus(1'b1, `GMT_ADDR_IRQ_STAT, 32'h01);
        look(1'b0);
        bus(1'b0, `GMT_ADDR_IRQ_STAT, 32'h00);
        repeat (4) begin
            v = $urandom & 32'h0000_00FF;
            bus(1'b1, `GMT_ADDR_MODULO, v);
            bus(1'b0, `GMT_ADDR_MODULO, v);
        end
        // gate pulses: rising/falling and falling/rising, the first one overflows
        bus(1'b1, `GMT_ADDR_MODULO, 32'h02);
        bus(1'b1, `GMT_ADDR_IRQ_MASK, 32'h06);
        for (int g = 0; g < 2; g++) begin
            bus(1'b1, `GMT_ADDR_MODE, 32'h00);
            invert <= g[0];
            bus(1'b1, `GMT_ADDR_MODE, gm[g]);
            bus(1'b1, `GMT_ADDR_IRQ_STAT, 32'h07);
            bus(1'b1, `GMT_ADDR_CLKRUN, 32'h0C);
            repeat (4) @(posedge hclk);
            start <= 1'b1;
            width <= 16'(gp[g]);
            @(posedge hclk);
            start <= 1'b0;
            repeat (gp[g] / 2) @(posedge hclk);
            #1;
            `CHK(gate_open_out, 1'b1)
            repeat (gp[g] / 2 + 10) @(posedge hclk);
            #1;
            `CHK(gate_open_out, 1'b0)
            `CHK(irq, 1'b1)
            bus(1'b0, `GMT_ADDR_COUNT, gc[g]);
            bus(1'b0, `GMT_ADDR_MODE, ge[g]);
            // writing the flag bit back as 1 must keep it
            bus(1'b1, `GMT_ADDR_MODE, ge[g]);
            bus(1'b0, `GMT_ADDR_MODE, ge[g]);
            bus(1'b0, `GMT_ADDR_IRQ_STAT, gs[g]);
            bus(1'b1, `GMT_ADDR_CLKRUN, 32'h00);
        end
        close_out;
    end
endmodule
